// *** include/csr_pkg.sv ***
/*
 * Constants and types shared by the core state block: status bit positions,
 * register file map, stack pointer I/O addresses, ALU and stack operation codes.
 * Assumes an 8-bit core with 32 working registers and a 2 KB internal SRAM.
 */
package csr_pkg;
	localparam int          REG_COUNT      = 32;
	localparam int          REG_AW         = 5;
	localparam logic [15:0] REGFILE_FIRST  = 16'h0000;
	localparam logic [15:0] REGFILE_LAST   = 16'h001f;
	localparam logic [4:0]  PTR_X_LOW      = 5'h1a;
	localparam logic [4:0]  PTR_Y_LOW      = 5'h1c;
	localparam logic [4:0]  PTR_Z_LOW      = 5'h1e;
	localparam logic [5:0]  IO_STACK_LOW   = 6'h3d;
	localparam logic [5:0]  IO_STACK_HIGH  = 6'h3e;
	localparam int          SP_BITS        = 11;
	localparam logic [15:0] LAST_SRAM_ADDRESS = 16'h08ff;
	localparam logic [15:0] SP_MASK        = 16'h07ff;
	localparam logic [7:0]  STATUS_RESET   = 8'h00;
	localparam int          ST_I           = 7;
	localparam int          ST_T           = 6;
	localparam int          ST_H           = 5;
	localparam int          ST_S           = 4;
	localparam int          ST_V           = 3;
	localparam int          ST_N           = 2;
	localparam int          ST_Z           = 1;
	localparam int          ST_C           = 0;
	localparam logic [15:0] STEP_ONE       = 16'h0001;
	localparam logic [15:0] STEP_TWO       = 16'h0002;
	localparam logic [2:0]  IRQ_ENTRY_CYCLES = 3'h4;

	typedef enum logic [3:0] {
		CSR_ALU_NONE = 4'h0,
		CSR_ALU_ADD  = 4'h1,
		CSR_ALU_ADC  = 4'h2,
		CSR_ALU_SUB  = 4'h3,
		CSR_ALU_SBC  = 4'h4,
		CSR_ALU_AND  = 4'h5,
		CSR_ALU_OR   = 4'h6,
		CSR_ALU_XOR  = 4'h7,
		CSR_ALU_MOV  = 4'h8,
		CSR_ALU_BST  = 4'h9,
		CSR_ALU_BLD  = 4'ha,
		CSR_ALU_MOVW = 4'hb
	} csr_alu_type;

	typedef enum logic [2:0] {
		CSR_STK_NONE    = 3'h0,
		CSR_STK_PUSH1   = 3'h1,
		CSR_STK_POP1    = 3'h2,
		CSR_STK_CALL    = 3'h3,
		CSR_STK_RET     = 3'h4,
		CSR_STK_RETURN_FROM_IRQ    = 3'h5
	} csr_stk_type;

	typedef enum logic [1:0] {
		CSR_PTR_PLAIN = 2'h0,
		CSR_PTR_DISP  = 2'h1,
		CSR_PTR_POSTINC = 2'h2,
		CSR_PTR_PREDEC  = 2'h3
	} csr_ptr_type;
endpackage : csr_pkg

// *** include/csr_alu_if.sv ***
/*
 * Carrier between the core state block and its ALU.
 * Assumes both ends run on the one core clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface csr_alu_if;
	import csr_pkg::*;
	csr_alu_type op;
	logic [7:0]  a;
	logic [7:0]  b;
	logic [15:0] a16;
	logic [2:0]  bit_sel;
	logic [7:0]  flags_in;
	logic [7:0]  result;
	logic [15:0] result16;
	logic [7:0]  flags_out;
	logic        wide;
	modport core (output op, a, b, a16, bit_sel, flags_in, input result, result16, flags_out, wide);
	modport alu  (input op, a, b, a16, bit_sel, flags_in, output result, result16, flags_out, wide);
endinterface : csr_alu_if
`default_nettype wire

// *** design/csr_alu.sv ***
/*
 * Combinational ALU: arithmetic, logic and bit-copy operations with flags.
 * Assumes operands and the present status come from the core in the same cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module csr_alu
	import csr_pkg::*;
(
	// Operand and result carrier.
	csr_alu_if.alu bus
);
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic       sub_op;
	logic       carry_in;
	logic [7:0] bmux;
	logic [7:0] res;
	logic       v_flag;
	logic       n_flag;
	logic       arith;
	logic       logic_op;

	assign sub_op   = (bus.op == CSR_ALU_SUB) || (bus.op == CSR_ALU_SBC);
	assign carry_in = ((bus.op == CSR_ALU_ADC) || (bus.op == CSR_ALU_SBC)) & bus.flags_in[ST_C];
	assign bmux     = sub_op ? ~bus.b : bus.b;
	assign sum9     = sub_op ? ({1'b0, bus.a} + {1'b0, bmux} + 9'h001 - {8'h00, carry_in})
	                         : ({1'b0, bus.a} + {1'b0, bmux} + {8'h00, carry_in});
	assign nib5     = sub_op ? ({1'b0, bus.a[3:0]} + {1'b0, bmux[3:0]} + 5'h01 - {4'h0, carry_in})
	                         : ({1'b0, bus.a[3:0]} + {1'b0, bmux[3:0]} + {4'h0, carry_in});
	assign arith    = (bus.op >= CSR_ALU_ADD) && (bus.op <= CSR_ALU_SBC);
	assign logic_op = (bus.op >= CSR_ALU_AND) && (bus.op <= CSR_ALU_XOR);

	always_comb begin
		case (bus.op)
			CSR_ALU_ADD, CSR_ALU_ADC, CSR_ALU_SUB, CSR_ALU_SBC: res = sum9[7:0];
			CSR_ALU_AND: res = bus.a & bus.b;
			CSR_ALU_OR:  res = bus.a | bus.b;
			CSR_ALU_XOR: res = bus.a ^ bus.b;
			CSR_ALU_MOV: res = bus.b;
			CSR_ALU_BLD: begin
				res = bus.a;
				res[bus.bit_sel] = bus.flags_in[ST_T];
			end
			default: res = bus.a;
		endcase
	end

	assign n_flag = res[7];
	assign v_flag = arith & ((bus.a[7] == bmux[7]) && (res[7] != bus.a[7]));

	always_comb begin
		bus.flags_out = bus.flags_in;
		if (arith || logic_op) begin
			bus.flags_out[ST_N] = n_flag;
			bus.flags_out[ST_Z] = (res == 8'h00);
			bus.flags_out[ST_V] = v_flag;
			bus.flags_out[ST_S] = n_flag ^ v_flag;
		end
		if (arith) begin
			bus.flags_out[ST_C] = sub_op ? ~sum9[8] : sum9[8];
			bus.flags_out[ST_H] = sub_op ? ~nib5[4] : nib5[4];
		end
		if (bus.op == CSR_ALU_BST)
			bus.flags_out[ST_T] = bus.a[bus.bit_sel];
	end

	assign bus.result   = res;
	assign bus.result16 = bus.a16;
	assign bus.wide     = (bus.op == CSR_ALU_MOVW);
endmodule : csr_alu
`default_nettype wire

// *** design/csr_core_state.sv ***
/*
 * Core state block: working registers, status flags and stack pointer.
 * Assumes a decoder on the same clock issues one request per cycle at most.
 */
`timescale 1ns/1ns
`default_nettype none
module csr_core_state
	import csr_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// ALU request from the decoder.
	input  wire logic        exec_i,
	input  wire csr_alu_type alu_op_i,
	input  wire logic [4:0]  rd_sel_i,
	input  wire logic [4:0]  rr_sel_i,
	input  wire logic        use_imm_i,
	input  wire logic [7:0]  imm_i,
	input  wire logic [2:0]  bit_sel_i,
	// Interrupt gate control.
	input  wire logic        irq_pending_i,
	input  wire logic        irq_accept_i,
	input  wire logic        set_gate_i,
	input  wire logic        clear_gate_i,
	// Stack requests and I/O access to status and stack pointer.
	input  wire csr_stk_type stk_op_i,
	input  wire logic        io_we_i,
	input  wire logic        io_re_i,
	input  wire logic [5:0]  io_addr_i,
	input  wire logic [7:0]  io_wdata_i,
	input  wire logic        status_we_i,
	// Data space access and pointer addressing.
	input  wire logic        ds_we_i,
	input  wire logic [15:0] ds_addr_i,
	input  wire logic [7:0]  ds_wdata_i,
	input  wire logic        ptr_req_i,
	input  wire logic [4:0]  ptr_sel_i,
	input  wire csr_ptr_type ptr_mode_i,
	input  wire logic [5:0]  ptr_disp_i,
	// Results.
	output logic [7:0]       status_o,
	output logic [15:0]      stack_ptr_o,
	output logic [7:0]       io_rdata_o,
	output logic [7:0]       ds_rdata_o,
	output logic             ds_hit_o,
	output logic [15:0]      ptr_addr_o,
	output logic             irq_take_o,
	output logic [7:0]       rd_value_o
);
	logic [7:0]  regs_r [REG_COUNT];
	logic [7:0]  status_r;
	logic [7:0]  status_nxt;
	logic [15:0] sp_r;
	logic [15:0] sp_nxt;
	logic        return_from_irq_hold_r;
	logic [7:0]  io_rdata_r;
	logic [7:0]  ds_rdata_r;
	logic        ds_hit_r;
	logic [15:0] ptr_addr_r;
	logic        irq_take_r;
	logic [7:0]  rd_value_r;

	csr_alu_if alu_bus ();
	csr_alu u_alu (.bus(alu_bus));

	function automatic logic [15:0] pair_of(input logic [7:0] lo, input logic [7:0] hi);
		pair_of = {hi, lo};
	endfunction : pair_of

	// Operand selection and ALU hookup.
	wire logic [4:0]  rd_pair = {rd_sel_i[4:1], 1'b0};
	wire logic [4:0]  rr_pair = {rr_sel_i[4:1], 1'b0};
	wire logic [7:0]  op_b    = use_imm_i ? imm_i : regs_r[rr_sel_i];
	assign alu_bus.op       = exec_i ? alu_op_i : CSR_ALU_NONE;
	assign alu_bus.a        = regs_r[rd_sel_i];
	assign alu_bus.b        = op_b;
	assign alu_bus.a16      = pair_of(regs_r[rr_pair], regs_r[rr_pair + 5'h01]);
	assign alu_bus.bit_sel  = bit_sel_i;
	assign alu_bus.flags_in = status_r;

	// Writes to the register file.
	wire logic        alu_wr  = exec_i && (alu_op_i != CSR_ALU_NONE) && (alu_op_i != CSR_ALU_BST);
	wire logic        ds_reg  = (ds_addr_i >= REGFILE_FIRST) && (ds_addr_i <= REGFILE_LAST);
	wire logic [4:0]  ds_idx  = ds_addr_i[4:0];

	// Pointer addressing.
	wire logic [4:0]  ptr_lo  = {ptr_sel_i[4:1], 1'b0};
	wire logic [15:0] ptr_val = pair_of(regs_r[ptr_lo], regs_r[ptr_lo + 5'h01]);
	wire logic [15:0] ptr_dec = ptr_val - STEP_ONE;
	wire logic [15:0] ptr_inc = ptr_val + STEP_ONE;
	wire logic        ptr_upd = ptr_req_i && ((ptr_mode_i == CSR_PTR_POSTINC) || (ptr_mode_i == CSR_PTR_PREDEC));
	wire logic [15:0] ptr_new = (ptr_mode_i == CSR_PTR_PREDEC) ? ptr_dec : ptr_inc;
	logic [15:0] ptr_eff;
	always_comb begin
		case (ptr_mode_i)
			CSR_PTR_DISP:   ptr_eff = ptr_val + {10'h000, ptr_disp_i};
			CSR_PTR_PREDEC: ptr_eff = ptr_dec;
			default:        ptr_eff = ptr_val;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (alu_wr && alu_bus.wide) begin
			regs_r[rd_pair]         <= alu_bus.result16[7:0];
			regs_r[rd_pair + 5'h01] <= alu_bus.result16[15:8];
		end else if (alu_wr)
			regs_r[rd_sel_i] <= alu_bus.result;
		if (ptr_upd) begin
			regs_r[ptr_lo]         <= ptr_new[7:0];
			regs_r[ptr_lo + 5'h01] <= ptr_new[15:8];
		end
		if (ds_we_i && ds_reg)
			regs_r[ds_idx] <= ds_wdata_i;
	end

	// Status register: flags, gate and I/O writes.
	wire logic gate_open = status_r[ST_I] && !return_from_irq_hold_r;
	wire logic irq_go    = irq_pending_i && gate_open && !clear_gate_i;
	always_comb begin
		status_nxt = exec_i ? alu_bus.flags_out : status_r;
		if (status_we_i)
			status_nxt = io_wdata_i;
		if (set_gate_i || (stk_op_i == CSR_STK_RETURN_FROM_IRQ))
			status_nxt[ST_I] = 1'b1;
		if (clear_gate_i || irq_accept_i)
			status_nxt[ST_I] = 1'b0;
		status_nxt[ST_S] = status_nxt[ST_N] ^ status_nxt[ST_V];
	end

	// Stack pointer.
	wire logic io_sp_lo = io_we_i && (io_addr_i == IO_STACK_LOW);
	wire logic io_sp_hi = io_we_i && (io_addr_i == IO_STACK_HIGH);
	always_comb begin
		case (stk_op_i)
			CSR_STK_PUSH1: sp_nxt = sp_r - STEP_ONE;
			CSR_STK_POP1:  sp_nxt = sp_r + STEP_ONE;
			CSR_STK_CALL:  sp_nxt = sp_r - STEP_TWO;
			CSR_STK_RET, CSR_STK_RETURN_FROM_IRQ: sp_nxt = sp_r + STEP_TWO;
			default:       sp_nxt = sp_r;
		endcase
		if (io_sp_lo)
			sp_nxt[7:0] = io_wdata_i;
		if (io_sp_hi)
			sp_nxt[15:8] = io_wdata_i;
		sp_nxt = sp_nxt & SP_MASK;
	end

	// Clocked state; interrupt entry clears and interrupt return sets the I bit of status.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			status_r    <= STATUS_RESET;
			sp_r        <= LAST_SRAM_ADDRESS & SP_MASK;
			return_from_irq_hold_r <= 1'b0;
		end else begin
			status_r    <= status_nxt;
			sp_r        <= sp_nxt;
			return_from_irq_hold_r <= (stk_op_i == CSR_STK_RETURN_FROM_IRQ) || (set_gate_i && !status_r[ST_I]);
		end
	end

	// Registered outputs, one per core clock cycle.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			io_rdata_r <= 8'h00;
			ds_rdata_r <= 8'h00;
			ds_hit_r   <= 1'b0;
			ptr_addr_r <= 16'h0000;
			irq_take_r <= 1'b0;
			rd_value_r <= 8'h00;
		end else begin
			io_rdata_r <= !io_re_i ? 8'h00 :
			              (io_addr_i == IO_STACK_LOW)  ? sp_r[7:0] :
			              (io_addr_i == IO_STACK_HIGH) ? sp_r[15:8] : 8'h00;
			ds_rdata_r <= ds_reg ? regs_r[ds_idx] : 8'h00;
			ds_hit_r   <= ds_reg;
			ptr_addr_r <= ptr_eff;
			irq_take_r <= irq_go;
			rd_value_r <= alu_wr ? alu_bus.result : regs_r[rd_sel_i];
		end
	end

	assign status_o    = status_r;
	assign stack_ptr_o = sp_r;
	assign io_rdata_o  = io_rdata_r;
	assign ds_rdata_o  = ds_rdata_r;
	assign ds_hit_o    = ds_hit_r;
	assign ptr_addr_o  = ptr_addr_r;
	assign irq_take_o  = irq_take_r;
	assign rd_value_o  = rd_value_r;

	// Assertions.
	a_sign_bit_xor: assert property (@(posedge clk_i) disable iff (!resetn_i)
		status_r[ST_S] == (status_r[ST_N] ^ status_r[ST_V])) else $error("sign bit mismatch");
	a_gate_blocks: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!status_r[ST_I] |=> !irq_take_r) else $error("interrupt taken with gate closed");
	a_accept_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
		irq_accept_i && !set_gate_i |=> !status_r[ST_I]) else $error("accept did not clear gate");
	a_return_from_irq_sets: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(stk_op_i == CSR_STK_RETURN_FROM_IRQ) && !clear_gate_i && !irq_accept_i |=> status_r[ST_I]) else $error("return did not set gate");
	a_return_from_irq_one_more: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(stk_op_i == CSR_STK_RETURN_FROM_IRQ) |=> ##1 !irq_take_r) else $error("interrupt right after return");
	a_push_one: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(stk_op_i == CSR_STK_PUSH1) && !io_we_i |=> sp_r == (($past(sp_r) - STEP_ONE) & SP_MASK)) else $error("push step wrong");
	a_call_two: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(stk_op_i == CSR_STK_CALL) && !io_we_i |=> sp_r == (($past(sp_r) - STEP_TWO) & SP_MASK)) else $error("call step wrong");
	a_ret_two: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(stk_op_i == CSR_STK_RET) && !io_we_i |=> sp_r == (($past(sp_r) + STEP_TWO) & SP_MASK)) else $error("return step wrong");
	a_sp_masked: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(sp_r & ~SP_MASK) == 16'h0000) else $error("stack pointer high bits set");
	a_reset_values: assert property (@(posedge clk_i)
		!resetn_i |=> status_r == STATUS_RESET && sp_r == (LAST_SRAM_ADDRESS & SP_MASK)) else $error("reset value wrong");
	c_irq_taken: cover property (@(posedge clk_i) disable iff (!resetn_i) irq_take_r);
	c_return_from_irq: cover property (@(posedge clk_i) disable iff (!resetn_i) stk_op_i == CSR_STK_RETURN_FROM_IRQ);
	c_wide_write: cover property (@(posedge clk_i) disable iff (!resetn_i) alu_wr && alu_bus.wide);
	c_ptr_inc: cover property (@(posedge clk_i) disable iff (!resetn_i) ptr_upd);
endmodule : csr_core_state
`default_nettype wire

// *** dv/csr_dec_model.sv ***
/*
 * Decoder model: issues ALU, stack and interrupt accept requests.
 * Assumes requests change one time unit after the rising clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module csr_dec_model
	import csr_pkg::*;
(
	// Clock.
	input  wire logic       clk_i,
	// Requests to the core state block.
	output var csr_alu_type op_o,
	output logic            exec_o,
	output logic [4:0]      rd_o,
	output logic [4:0]      rr_o,
	output logic            imm_en_o,
	output logic [7:0]      imm_o,
	output logic [2:0]      bit_o,
	output var csr_stk_type stk_o,
	output logic            acc_o
);
	initial begin
		{exec_o, rd_o, rr_o, imm_en_o, imm_o, bit_o, acc_o} = '0;
		op_o = CSR_ALU_NONE;
		stk_o = CSR_STK_NONE;
	end
	// Issues one ALU request and waits one cycle; exec_o stays set until idle.
	task alu(input csr_alu_type op, input logic [4:0] rd, rr, input logic ie, input logic [7:0] im, input logic [2:0] bs);
		op_o = op;
		{rd_o, rr_o, imm_en_o, imm_o, bit_o} = {rd, rr, ie, im, bs};
		exec_o = 1'b1;
		@(posedge clk_i);
		#1;
	endtask : alu
	// Issues one stack request, with interrupt accept when entering a handler.
	task stk(input csr_stk_type op, input logic acc);
		stk_o = op;
		acc_o = acc;
		@(posedge clk_i);
		#1;
	endtask : stk
	// Returns all requests to idle for one cycle.
	task idle;
		exec_o = 1'b0;
		acc_o = 1'b0;
		stk_o = CSR_STK_NONE;
		@(posedge clk_i);
		#1;
	endtask : idle
endmodule : csr_dec_model
`default_nettype wire

// *** dv/tb.sv ***
/*
 * Self-checking bench for the core state block with random ALU traffic.
 * Assumes the decoder model drives the ALU and stack requests.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
	import csr_pkg::*;
	logic        clk_i, resetn_i, io_we_i, io_re_i, status_we_i, ds_we_i, ptr_req_i, exec_i, use_imm_i;
	logic        irq_pending_i, set_gate_i, clear_gate_i, irq_accept_i, ds_hit_o, irq_take_o, ie;
	logic [5:0]  io_addr_i, ptr_disp_i;
	logic [7:0]  io_wdata_i, ds_wdata_i, imm_i, status_o, io_rdata_o, ds_rdata_o, rd_value_o, st, a, b;
	logic [15:0] ds_addr_i, stack_ptr_o, ptr_addr_o, sp, e;
	logic [4:0]  rd_sel_i, rr_sel_i, ptr_sel_i, rd, rr;
	logic [2:0]  bit_sel_i;
	csr_alu_type alu_op_i, op;
	csr_stk_type stk_op_i;
	csr_ptr_type ptr_mode_i;
	int          error_cnt = 0, samples_checked = 0, cyc = 0, seed = 32'h873b1825;
	csr_alu_type ops[5] = '{CSR_ALU_ADD, CSR_ALU_SUB, CSR_ALU_AND, CSR_ALU_OR, CSR_ALU_XOR};
	csr_stk_type sops[6] = '{CSR_STK_PUSH1, CSR_STK_PUSH1, CSR_STK_CALL, CSR_STK_POP1, CSR_STK_RET, CSR_STK_CALL};
	logic [15:0] sdel[6] = '{16'hffff, 16'hffff, 16'hfffe, 16'h0001, 16'h0002, 16'hfffe};
	csr_ptr_type pm[5] = '{CSR_PTR_DISP, CSR_PTR_POSTINC, CSR_PTR_POSTINC, CSR_PTR_PREDEC, CSR_PTR_PLAIN};
	logic [15:0] pe[5] = '{16'h153d, 16'h14fe, 16'h14ff, 16'h14ff, 16'h14ff};

	csr_core_state dut (
		.clk_i, .resetn_i, .exec_i, .alu_op_i, .rd_sel_i, .rr_sel_i, .use_imm_i, .imm_i, .bit_sel_i,
		.irq_pending_i, .irq_accept_i, .set_gate_i, .clear_gate_i, .stk_op_i, .io_we_i, .io_re_i,
		.io_addr_i, .io_wdata_i, .status_we_i, .ds_we_i, .ds_addr_i, .ds_wdata_i, .ptr_req_i, .ptr_sel_i,
		.ptr_mode_i, .ptr_disp_i, .status_o, .stack_ptr_o, .io_rdata_o, .ds_rdata_o, .ds_hit_o,
		.ptr_addr_o, .irq_take_o, .rd_value_o
	);
	csr_dec_model dec (
		.clk_i, .op_o(alu_op_i), .exec_o(exec_i), .rd_o(rd_sel_i), .rr_o(rr_sel_i), .imm_en_o(use_imm_i),
		.imm_o(imm_i), .bit_o(bit_sel_i), .stk_o(stk_op_i), .acc_o(irq_accept_i)
	);

	// Works out result and status of an ALU operation.
	function automatic logic [15:0] ref_alu(input csr_alu_type f, input logic [7:0] x, y, s);
		logic [8:0] r;
		logic       v;
		v = 1'b0;
		r = {1'b0, x ^ y};
		if (f == CSR_ALU_AND) r = {1'b0, x & y};
		if (f == CSR_ALU_OR) r = {1'b0, x | y};
		if (f == CSR_ALU_ADD) begin
			r = {1'b0, x} + {1'b0, y};
			s[ST_H] = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
			v = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
			s[ST_C] = r[8];
		end
		if (f == CSR_ALU_SUB) begin
			r = {1'b0, x} - {1'b0, y};
			s[ST_H] = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
			v = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
			s[ST_C] = r[8];
		end
		{s[ST_V], s[ST_N], s[ST_Z], s[ST_S]} = {v, r[7], r[7:0] == 8'h00, r[7] ^ v};
		return {r[7:0], s};
	endfunction : ref_alu

	task step;
		@(posedge clk_i);
		#1;
	endtask : step
	task chk(input logic [15:0] s, input logic [15:0] x);
		samples_checked++;
		if (s !== x) begin
			error_cnt++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task summarize;
		if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	task wreg(input logic [4:0] r, input logic [7:0] v);
		{ds_addr_i, ds_wdata_i, ds_we_i} = {11'h000, r, v, 1'b1};
		step;
		ds_we_i = 1'b0;
		step;
	endtask : wreg
	task rreg(input logic [4:0] r, input logic [7:0] v);
		ds_addr_i = {11'h000, r};
		step;
		chk(ds_rdata_o, v);
		chk(ds_hit_o, 1'b1);
	endtask : rreg
	task iow(input logic [5:0] ad, input logic [7:0] v);
		{io_addr_i, io_wdata_i, io_we_i} = {ad, v, 1'b1};
		step;
		io_we_i = 1'b0;
		step;
	endtask : iow
	task ior(input logic [5:0] ad, input logic [7:0] v);
		{io_addr_i, io_re_i} = {ad, 1'b1};
		step;
		io_re_i = 1'b0;
		chk(io_rdata_o, v);
		step;
	endtask : ior
	task ptr(input logic [4:0] s, input csr_ptr_type m, input logic [5:0] d, input logic [15:0] x);
		{ptr_sel_i, ptr_disp_i, ptr_req_i} = {s, d, 1'b1};
		ptr_mode_i = m;
		step;
		ptr_req_i = 1'b0;
		chk(ptr_addr_o, x);
		step;
	endtask : ptr

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		{resetn_i, io_we_i, io_re_i, status_we_i, ds_we_i, ptr_req_i, irq_pending_i, set_gate_i, clear_gate_i} = '0;
		{io_addr_i, ptr_disp_i, io_wdata_i, ds_wdata_i, ds_addr_i, ptr_sel_i} = '0;
		ptr_mode_i = CSR_PTR_PLAIN;
		repeat (2) step;
		resetn_i = 1'b1;
		chk(status_o, STATUS_RESET);
		chk(stack_ptr_o, LAST_SRAM_ADDRESS & SP_MASK);
		chk(irq_take_o, 1'b0);
		st = STATUS_RESET;
		for (int i = 0; i < 24; i++) begin
			a = (i == 0) ? 8'h7f : 8'($random(seed));
			b = (i == 0) ? 8'h01 : 8'($random(seed));
			if (i == 1) b = a;
			op = ops[(i < 2) ? i : ($unsigned($random(seed)) % 5)];
			rd = 5'($random(seed));
			rr = rd ^ 5'h10;
			ie = i[0] & (i > 1);
			wreg(rd, a);
			wreg(rr, ie ? ~b : b);
			dec.alu(op, rd, rr, ie, b, 3'h0);
			e = ref_alu(op, a, b, st);
			st = e[7:0];
			chk(rd_value_o, e[15:8]);
			chk(status_o, st);
			dec.idle();
			rreg(rd, e[15:8]);
		end
		iow(IO_STACK_HIGH, 8'hff);
		iow(IO_STACK_LOW, 8'h01);
		sp = 16'hff01 & SP_MASK;
		chk(stack_ptr_o, sp);
		ior(IO_STACK_HIGH, sp[15:8]);
		ior(IO_STACK_LOW, sp[7:0]);
		ior(6'h10, 8'h00);
		for (int i = 0; i < 6; i++) begin
			dec.stk(sops[i], 1'b0);
			sp = (sp + sdel[i]) & SP_MASK;
			chk(stack_ptr_o, sp);
			dec.idle();
		end
		{io_wdata_i, status_we_i} = {8'h2f, 1'b1};
		step;
		status_we_i = 1'b0;
		st = 8'h2f;
		chk(status_o, st);
		irq_pending_i = 1'b1;
		step;
		chk(irq_take_o, 1'b0);
		set_gate_i = 1'b1;
		step;
		set_gate_i = 1'b0;
		st[ST_I] = 1'b1;
		chk(status_o, st);
		repeat (2) step;
		chk(irq_take_o, 1'b1);
		dec.stk(CSR_STK_CALL, 1'b1);
		st[ST_I] = 1'b0;
		sp = (sp - STEP_TWO) & SP_MASK;
		chk(status_o, st);
		chk(stack_ptr_o, sp);
		dec.idle();
		dec.stk(CSR_STK_RETURN_FROM_IRQ, 1'b0);
		st[ST_I] = 1'b1;
		sp = (sp + STEP_TWO) & SP_MASK;
		chk(status_o, st);
		chk(stack_ptr_o, sp);
		chk(irq_take_o, 1'b0);
		dec.idle();
		chk(irq_take_o, 1'b0);
		step;
		chk(irq_take_o, 1'b1);
		{set_gate_i, clear_gate_i} = 2'b11;
		step;
		{set_gate_i, clear_gate_i, irq_pending_i} = '0;
		st[ST_I] = 1'b0;
		chk(status_o, st);
		chk(irq_take_o, 1'b0);
		wreg(5'h03, 8'h20);
		dec.alu(CSR_ALU_BST, 5'h03, 5'h00, 1'b0, 8'h00, 3'h5);
		st[ST_T] = 1'b1;
		chk(status_o, st);
		dec.idle();
		wreg(5'h04, 8'h80);
		dec.alu(CSR_ALU_BLD, 5'h04, 5'h00, 1'b0, 8'h00, 3'h0);
		chk(rd_value_o, 8'h81);
		dec.idle();
		wreg(5'h10, 8'h5a);
		wreg(5'h11, 8'ha5);
		dec.alu(CSR_ALU_MOVW, 5'h02, 5'h10, 1'b0, 8'h00, 3'h0);
		dec.idle();
		rreg(5'h02, 8'h5a);
		rreg(5'h03, 8'ha5);
		{ds_addr_i, ds_we_i} = {REGFILE_LAST + 16'h0001, 1'b1};
		step;
		ds_we_i = 1'b0;
		step;
		chk(ds_hit_o, 1'b0);
		for (int p = 0; p < 3; p++) begin
			wreg(PTR_X_LOW + 5'(2 * p), 8'hfe);
			wreg(PTR_X_LOW + 5'(2 * p + 1), 8'h12 + 8'(p));
			ptr(PTR_X_LOW + 5'(2 * p), CSR_PTR_PLAIN, 6'h00, 16'h12fe + 16'(p << 8));
		end
		for (int m = 0; m < 5; m++) ptr(PTR_Z_LOW, pm[m], 6'h3f, pe[m]);
		rreg(PTR_Z_LOW, 8'hff);
		rreg(PTR_Z_LOW + 5'h01, 8'h14);
		summarize();
	end
endmodule : tb
`default_nettype wire
